//--- tb_uart_port.sv
`default_nettype none
// Self-checking bench for the serial port against the host model.
module tb_uart_port;
   timeunit 1ns;
   timeprecision 1ps;
   import uart_pkg::*;
   logic mclk = 1'b0;
   logic rst, tx_valid, tx_ready, tx_busy, rx_valid, rx_ack, rx_overrun;
   logic rxd, txd, cts_n, rts_n;
   logic [7:0] tx_data;
   cfg_t cfg;
   rx_word_t rx_word;
   real bit_ns = 1000.0; // Bit time for the host model.
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;
   // Format table; the second entry runs at the top rate.
   int baud_tab[4] = '{115200, 921600, 115200, 115200};
   len_t len_tab[4] = '{2'h3, 2'h0, 2'h1, 2'h2};
   parity_t par_tab[4] = '{PAR_NONE, PAR_ODD, PAR_EVEN, PAR_ODD};
   stop_t stop_tab[4] = '{STOP_1, STOP_1P5, STOP_2, STOP_1};

   always #25 mclk = ~mclk; // 20 MHz core clock.

   uart_port uut(.i_mclk(mclk), .i_rst(rst), .i_cfg(cfg), .i_tx_data(tx_data),
      .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_tx_busy(tx_busy),
      .o_rx_word(rx_word), .o_rx_valid(rx_valid), .i_rx_ack(rx_ack),
      .o_rx_overrun(rx_overrun), .i_rxd(rxd), .o_txd(txd), .i_cts_n(cts_n),
      .o_rts_n(rts_n));
   uart_host_model host(.i_cfg(cfg), .i_bit_ns(bit_ns), .i_txd(txd),
      .i_rts_n(rts_n), .o_rxd(rxd));

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   task automatic complete_run();
      $display("Checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // A hang counts as a mismatch; the tests need about 20k cycles.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         complete_run();
      end
   end

   // Settings change only between characters, off the sampling edge.
   task automatic set_cfg(input int k, input logic flow);
      @(negedge mclk);
      cfg = '{baud_increment(baud_tab[k]), par_tab[k], stop_tab[k], len_tab[k], flow};
      bit_ns = 1.0e9 / baud_tab[k];
      repeat (4) @(negedge mclk);
   endtask

   task automatic wait_rx();
      int n = 0;
      while (rx_valid !== 1'b1 && n < 30000) begin
         @(negedge mclk);
         n++;
      end
      chk("rx_valid_seen", 1, rx_valid);
   endtask

   // Judge the held word, then acknowledge it with a one-cycle pulse.
   task automatic rx_take(input logic [7:0] d, input logic pe, input logic fe);
      wait_rx();
      chk("rx_data", d, rx_word.data);
      chk("rx_par_err", pe, rx_word.par_err);
      chk("rx_frame_err", fe, rx_word.frame_err);
      @(negedge mclk);
      rx_ack = 1'b1;
      @(negedge mclk);
      rx_ack = 1'b0;
   endtask

   // Offer a word until taken; cyc counts the cycles busy stands.
   task automatic tx_word(input logic [7:0] d, output int cyc);
      int n = 0;
      cyc = 0;
      @(negedge mclk);
      tx_data = d;
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1 && n < 30000) begin
         @(negedge mclk);
         n++;
      end
      @(negedge mclk);
      tx_valid = 1'b0;
      while (tx_busy === 1'b1 && cyc < 30000) begin
         @(negedge mclk);
         cyc++;
      end
      chk("tx_offer_taken", 1, n < 30000);
      chk("tx_busy_end", 0, tx_busy);
   endtask

   // Both directions at once, one format from the table.
   task automatic duplex(input int k);
      logic [7:0] d;
      logic [7:0] m;
      int cyc;
      int st;
      real want;
      set_cfg(k, 1'b0);
      d = 8'hc5 ^ 8'(k << 3);
      m = 8'hff >> (3 - len_tab[k]);
      fork
         host.send(~d, 1'b0, 1'b0);
         tx_word(d, cyc);
      join
      chk("line_data", d & m, host.got_data);
      if (par_tab[k] != PAR_NONE) chk("line_par", host.par_of(d), host.got_par);
      chk("line_stop", 1, host.got_stop);
      st = stop_tab[k] == STOP_2 ? TICKS_STOP_2 :
         stop_tab[k] == STOP_1P5 ? TICKS_STOP_1P5 : TICKS_STOP_1;
      want = (16.0 * (6 + len_tab[k] + (par_tab[k] != PAR_NONE)) + st) * CLK_HZ;
      want = want / (16.0 * baud_tab[k]);
      chk("tx_char_cycles", 1, cyc > want * 0.97 && cyc < want * 1.03);
      rx_take(~d & m, 1'b0, 1'b0);
   endtask

   task automatic faults();
      set_cfg(2, 1'b0);
      host.send(8'h15, 1'b1, 1'b0);
      rx_take(8'h15, 1'b1, 1'b0);
      host.send(8'h2a, 1'b0, 1'b1);
      rx_take(8'h2a, 1'b0, 1'b1);
   endtask

   // Second character lost while the first is held.
   task automatic overrun();
      set_cfg(0, 1'b0);
      host.send(8'h11, 1'b0, 1'b0);
      host.send(8'h22, 1'b0, 1'b0);
      wait_rx();
      chk("overrun_set", 1, rx_overrun);
      rx_take(8'h11, 1'b0, 1'b0);
      repeat (2) @(negedge mclk);
      chk("overrun_clear", 0, rx_overrun);
      chk("valid_clear", 0, rx_valid);
   endtask

   // A held word raises request-to-send and holds the host off.
   task automatic rts_flow();
      set_cfg(0, 1'b1);
      chk("rts_free", 0, rts_n);
      host.send(8'h33, 1'b0, 1'b0);
      wait_rx();
      repeat (3) @(negedge mclk);
      chk("rts_held", 1, rts_n);
      fork
         host.send(8'h44, 1'b0, 1'b0);
      join_none
      repeat (400) @(negedge mclk);
      chk("no_overrun", 0, rx_overrun);
      rx_take(8'h33, 1'b0, 1'b0);
      rx_take(8'h44, 1'b0, 1'b0);
      wait fork;
   endtask

   // Clear-to-send gates starts but never cuts a character short.
   task automatic cts_gate();
      int cyc;
      logic hi;
      hi = 1'b1;
      set_cfg(0, 1'b1);
      cts_n = 1'b1;
      repeat (4) @(negedge mclk);
      chk("ready_blocked", 0, tx_ready);
      fork
         tx_word(8'h3c, cyc);
      join_none
      repeat (400) begin
         @(negedge mclk);
         hi = hi & txd;
      end
      chk("txd_held", 1, hi);
      cts_n = 1'b0;
      #(bit_ns * 3.0);
      @(negedge mclk);
      cts_n = 1'b1;
      wait fork;
      chk("char_finished", 8'h3c, host.got_data);
      chk("ready_after", 0, tx_ready);
      cts_n = 1'b0;
   endtask

   initial begin
      cfg = '{BAUD_INC_RESET, PAR_NONE, STOP_1, 2'h3, 1'b0};
      rst = 1'b1;
      tx_data = 8'h00;
      tx_valid = 1'b0;
      rx_ack = 1'b0;
      cts_n = 1'b0;
      repeat (4) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      chk("reset_txd", 1, txd);
      chk("reset_valid", 0, rx_valid);
      for (int k = 0; k < 4; k++) duplex(k);
      faults();
      overrun();
      rts_flow();
      cts_gate();
      complete_run();
   end
endmodule // tb_uart_port
`default_nettype wire

//--- uart_baud_gen.sv
`default_nettype none
module uart_baud_gen #(
   parameter int unsigned ACC_W = uart_pkg::ACC_W
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [ACC_W-1:0] i_inc,
   output logic o_tick
);
   import uart_pkg::*;

   // Phase accumulator; its carry is the sample tick.
   logic [ACC_W-1:0] acc_ff;
   logic [ACC_W:0] nxt_sum;
   logic tick_ff;

   // A fractional step keeps the long-run rate exact even at the top rate,
   // where a whole-cycle divider would miss the error bound; the cost is one
   // cycle of jitter per tick, well inside a bit.
   always_comb begin
      nxt_sum = {1'b0, acc_ff} + {1'b0, i_inc};
   end

   // Accumulate every cycle and flag the overflow as a one-cycle tick.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         acc_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         acc_ff <= nxt_sum[ACC_W-1:0];
         tick_ff <= nxt_sum[ACC_W];
      end
   end

   assign o_tick = tick_ff;
endmodule // uart_baud_gen
`default_nettype wire

//--- uart_host_model.sv
`default_nettype none
// Serial host on the far side: sends on rxd and listens on txd.
module uart_host_model
   import uart_pkg::*;
(
   input wire cfg_t i_cfg,
   input var real i_bit_ns,
   input wire logic i_txd,
   input wire logic i_rts_n,
   output logic o_rxd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got_data; // Last character seen on txd.
   logic got_par; // Its parity bit.
   logic got_stop; // Its first stop level.
   initial o_rxd = 1'b1; // The line idles high.

   // Parity over the live bits; odd mode inverts the sum.
   function automatic logic par_of(input logic [7:0] d);
      par_of = ^(d & (8'hff >> (3 - i_cfg.len))) ^ (i_cfg.parity == PAR_ODD);
   endfunction

   // Sample each bit in its middle, timed from the falling start edge.
   always begin
      @(negedge i_txd);
      #(i_bit_ns * 1.5);
      got_data = 8'h00;
      for (int i = 0; i < i_cfg.len + 5; i++) begin
         got_data[i] = i_txd;
         #(i_bit_ns);
      end
      if (i_cfg.parity != PAR_NONE) begin
         got_par = i_txd;
         #(i_bit_ns);
      end
      got_stop = i_txd;
   end

   // One character, LSB first, then stop time plus one idle bit.
   task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
      if (i_cfg.flow_en) wait (i_rts_n === 1'b0);
      o_rxd = 1'b0;
      #(i_bit_ns);
      for (int i = 0; i < i_cfg.len + 5; i++) begin
         o_rxd = d[i];
         #(i_bit_ns);
      end
      if (i_cfg.parity != PAR_NONE) begin
         o_rxd = par_of(d) ^ bad_par;
         #(i_bit_ns);
      end
      // A short low stop gives a framing fault without faking a new start.
      if (bad_stop) begin
         o_rxd = 1'b0;
         #(i_bit_ns * 0.6);
      end
      o_rxd = 1'b1;
      #(i_bit_ns * (2.0 + 0.5 * (i_cfg.stop != STOP_1) + 0.5 * (i_cfg.stop == STOP_2)));
   endtask
endmodule // uart_host_model
`default_nettype wire

//--- uart_pkg.sv
`default_nettype none
package uart_pkg;
   // Core clock rate and the character timing derived from it.
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned BAUD_MIN = 1200;
   localparam int unsigned BAUD_MAX = 921600;
   localparam int unsigned BAUD_DEFAULT = 115200;
   // Each bit is split into sixteen sample ticks.
   // Tick counts are six bits wide so that a two-bit stop period of 32 fits.
   localparam int unsigned OSR = 16;
   localparam logic [5:0] TICKS_BIT = 6'h10;
   localparam logic [5:0] TICKS_STOP_1 = 6'h10;
   localparam logic [5:0] TICKS_STOP_1P5 = 6'h18;
   localparam logic [5:0] TICKS_STOP_2 = 6'h20;
   // Receiver checks the start bit half a bit in, then samples mid-bit.
   localparam logic [3:0] RX_START_MID = 4'h7;
   localparam logic [3:0] RX_BIT_END = 4'hf;
   // Phase accumulator width of the tick generator.
   localparam int unsigned ACC_W = 24;
   localparam logic [ACC_W-1:0] BAUD_INC_RESET = ACC_W'(
      (longint'(BAUD_DEFAULT) * OSR * (longint'(1) << ACC_W)) / CLK_HZ);

   typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} parity_t;
   typedef enum logic [1:0] {STOP_1, STOP_1P5, STOP_2} stop_t;
   // Character length code: 0 means 5 bits up to 3 meaning 8 bits.
   typedef logic [1:0] len_t;

   // Line settings, held steady by the processor while characters move.
   typedef struct packed {
      logic [ACC_W-1:0] baud_inc;
      parity_t parity;
      stop_t stop;
      len_t len;
      logic flow_en;
   } cfg_t;

   // One received character with its error flags.
   typedef struct packed {
      logic [7:0] data;
      logic par_err;
      logic frame_err;
   } rx_word_t;

   // Accumulator step for a baud rate, for use by whoever sets cfg_t.
   function automatic logic [ACC_W-1:0] baud_increment(input int unsigned baud);
      baud_increment = ACC_W'((longint'(baud) * OSR * (longint'(1) << ACC_W)) / CLK_HZ);
   endfunction

   // Parity bit over the live data bits; even parity makes the total even.
   function automatic logic parity_bit(input logic [7:0] d, input len_t len,
                                       input parity_t mode);
      logic [7:0] mask;
      mask = 8'hff >> (3'h3 - 3'(len));
      parity_bit = ^(d & mask);
      if (mode == PAR_ODD) begin
         parity_bit = ~parity_bit;
      end
   endfunction
endpackage
`default_nettype wire

//--- uart_port.sv
`default_nettype none
// What this block does
// [RULE_01] One full-duplex channel, independent transmit and receive.
// [RULE_02] Deserialise input characters; serialise written words.
// [RULE_03] Request and clear to send are low-active.
// [RULE_04] Host stops sending while request is high.
// [RULE_05] Rates, parity, stop bits, lengths, flow selectable.
// [RULE_06] Clear high: finish character, then hold off.
module uart_port (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire uart_pkg::cfg_t i_cfg,
   input wire logic [7:0] i_tx_data,
   input wire logic i_tx_valid,
   output logic o_tx_ready,
   output logic o_tx_busy,
   output uart_pkg::rx_word_t o_rx_word,
   output logic o_rx_valid,
   input wire logic i_rx_ack,
   output logic o_rx_overrun,
   input wire logic i_rxd,
   output logic o_txd,
   input wire logic i_cts_n,
   output logic o_rts_n
);
   import uart_pkg::*;

   typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
   typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

   logic tick; // Sixteen-per-bit sample tick.
   logic rxd_meta_ff, rxd_ff; // Receive line synchroniser.
   logic cts_meta_ff, cts_n_ff; // Clear-to-send synchroniser.
   tx_state_t tx_state_ff;
   logic [5:0] tx_tk_ff; // Ticks spent in the current transmit bit.
   logic [2:0] tx_bit_ff; // Index of the data bit on the line.
   logic [7:0] tx_sh_ff; // Character being sent.
   logic txd_ff;
   logic [5:0] stop_ticks; // Length of the stop period in ticks.
   logic tx_bit_done;
   logic tx_may_start;
   rx_state_t rx_state_ff;
   logic [3:0] rx_tk_ff; // Ticks within the current receive bit.
   logic [2:0] rx_bit_ff;
   logic [7:0] rx_sh_ff; // Bits gathered so far.
   logic rx_perr_ff; // Parity mismatch of the character in flight.
   rx_word_t rx_word_ff;
   logic rx_valid_ff;
   logic rx_ovr_ff;
   logic rx_done; // Pulse when a full character has been sampled.
   logic rx_mid; // Mid-bit sample point.
   logic rts_n_ff;

   // One tick source serves both directions; each keeps its own counters,
   // so the paths never wait on one another.
   uart_baud_gen #(.ACC_W(ACC_W)) u_baud ( // RULE_01
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_inc(i_cfg.baud_inc),
      .o_tick(tick)
   );

   // Both line inputs come from outside and pass two flops first.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         rxd_meta_ff <= 1'b1;
         rxd_ff <= 1'b1;
         cts_meta_ff <= 1'b1;
         cts_n_ff <= 1'b1;
      end else begin
         rxd_meta_ff <= i_rxd;
         rxd_ff <= rxd_meta_ff;
         cts_meta_ff <= i_cts_n;
         cts_n_ff <= cts_meta_ff;
      end
   end

   // Stop period of one, one and a half or two bits.
   always_comb begin
      case (i_cfg.stop) // RULE_05
         STOP_1P5: stop_ticks = TICKS_STOP_1P5;
         STOP_2: stop_ticks = TICKS_STOP_2;
         default: stop_ticks = TICKS_STOP_1;
      endcase
   end

   // A new character may start only when clear-to-send is low, or flow
   // control is off; a character already running is never cut short.
   assign tx_may_start = !i_cfg.flow_en || !cts_n_ff; // RULE_03 RULE_06
   assign o_tx_ready = (tx_state_ff == TX_IDLE) && tx_may_start;
   assign o_tx_busy = (tx_state_ff != TX_IDLE);
   assign tx_bit_done = tick && (tx_tk_ff == TICKS_BIT - 6'h01);

   // Transmit sequencer: start, data LSB first, optional parity, stop.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         tx_state_ff <= TX_IDLE;
         tx_tk_ff <= '0;
         tx_bit_ff <= '0;
         tx_sh_ff <= '0;
      end else begin
         if (tick) begin
            tx_tk_ff <= tx_tk_ff + 6'h01;
         end
         case (tx_state_ff)
            TX_IDLE: begin
               tx_tk_ff <= '0;
               if (i_tx_valid && tx_may_start) begin // RULE_06
                  tx_sh_ff <= i_tx_data;
                  tx_bit_ff <= '0;
                  tx_state_ff <= TX_START;
               end
            end
            TX_START: begin
               if (tx_bit_done) begin
                  tx_tk_ff <= '0;
                  tx_state_ff <= TX_DATA;
               end
            end
            TX_DATA: begin
               if (tx_bit_done) begin // RULE_02
                  tx_tk_ff <= '0;
                  tx_bit_ff <= tx_bit_ff + 3'h1;
                  if (tx_bit_ff == 3'h4 + 3'(i_cfg.len)) begin
                     tx_state_ff <= (i_cfg.parity == PAR_NONE) ? TX_STOP : TX_PAR;
                  end
               end
            end
            TX_PAR: begin
               if (tx_bit_done) begin
                  tx_tk_ff <= '0;
                  tx_state_ff <= TX_STOP;
               end
            end
            TX_STOP: begin
               if (tick && (tx_tk_ff == stop_ticks - 6'h01)) begin // RULE_05
                  tx_tk_ff <= '0;
                  tx_state_ff <= TX_IDLE;
               end
            end
            default: tx_state_ff <= TX_IDLE;
         endcase
      end
   end

   // Line level follows the state; held in a flop so the pin never glitches.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         txd_ff <= 1'b1;
      end else begin
         case (tx_state_ff)
            TX_START: txd_ff <= 1'b0;
            TX_DATA: txd_ff <= tx_sh_ff[tx_bit_ff]; // RULE_02
            TX_PAR: txd_ff <= parity_bit(tx_sh_ff, i_cfg.len, i_cfg.parity);
            default: txd_ff <= 1'b1;
         endcase
      end
   end
   assign o_txd = txd_ff;

   assign rx_mid = tick && (rx_tk_ff == RX_BIT_END);
   assign rx_done = (rx_state_ff == RX_STOP) && rx_mid;

   // Receive sequencer: falling edge starts, start bit is confirmed half a
   // bit in, and every later bit is sampled one bit further on.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         rx_state_ff <= RX_IDLE;
         rx_tk_ff <= '0;
         rx_bit_ff <= '0;
         rx_sh_ff <= '0;
         rx_perr_ff <= 1'b0;
      end else begin
         if (tick) begin
            rx_tk_ff <= rx_tk_ff + 4'h1;
         end
         case (rx_state_ff)
            RX_IDLE: begin
               rx_tk_ff <= '0;
               if (!rxd_ff) begin
                  rx_state_ff <= RX_START;
                  rx_sh_ff <= '0;
                  rx_bit_ff <= '0;
                  rx_perr_ff <= 1'b0;
               end
            end
            RX_START: begin
               if (tick && (rx_tk_ff == RX_START_MID)) begin
                  rx_tk_ff <= '0;
                  // A glitch shorter than half a bit is dropped.
                  rx_state_ff <= rxd_ff ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rx_mid) begin // RULE_02
                  rx_sh_ff[rx_bit_ff] <= rxd_ff;
                  rx_bit_ff <= rx_bit_ff + 3'h1;
                  if (rx_bit_ff == 3'h4 + 3'(i_cfg.len)) begin
                     rx_state_ff <= (i_cfg.parity == PAR_NONE) ? RX_STOP : RX_PAR;
                  end
               end
            end
            RX_PAR: begin
               if (rx_mid) begin
                  rx_perr_ff <= rxd_ff != parity_bit(rx_sh_ff, i_cfg.len, i_cfg.parity);
                  rx_state_ff <= RX_STOP;
               end
            end
            RX_STOP: begin
               // Only the first stop bit is checked, so the receiver is ready
               // for the next start edge as early as possible.
               if (rx_mid) begin
                  rx_state_ff <= RX_IDLE;
               end
            end
            default: rx_state_ff <= RX_IDLE;
         endcase
      end
   end

   // Holding word for the processor; a new character replaces it only when
   // it has been taken, otherwise the overrun flag is raised.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         rx_word_ff <= '0;
         rx_valid_ff <= 1'b0;
      end else if (rx_done && (!rx_valid_ff || i_rx_ack)) begin
         rx_word_ff.data <= rx_sh_ff;
         rx_word_ff.par_err <= rx_perr_ff;
         rx_word_ff.frame_err <= !rxd_ff;
         rx_valid_ff <= 1'b1;
      end else if (i_rx_ack) begin
         rx_valid_ff <= 1'b0;
      end
   end

   // Overrun is sticky until the next acknowledge; a character finishing in the
   // acknowledging cycle is stored instead, and the flag clears.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         rx_ovr_ff <= 1'b0;
      end else if (rx_done && rx_valid_ff && !i_rx_ack) begin
         rx_ovr_ff <= 1'b1;
      end else if (i_rx_ack) begin
         rx_ovr_ff <= 1'b0;
      end
   end

   // Request-to-send goes high while the holding word is full, telling the
   // host to pause; it relies on the host honouring it within a character.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         rts_n_ff <= 1'b1;
      end else begin
         rts_n_ff <= i_cfg.flow_en && rx_valid_ff; // RULE_03 RULE_04
      end
   end

   assign o_rx_word = rx_word_ff;
   assign o_rx_valid = rx_valid_ff;
   assign o_rx_overrun = rx_ovr_ff;
   assign o_rts_n = rts_n_ff;

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   sequence s_tx_load;
      i_tx_valid && o_tx_ready;
   endsequence
   sequence s_start_low;
      (tx_state_ff == TX_START) ##1 (o_txd == 1'b0);
   endsequence

   a_tx_start_bit: assert property (s_tx_load |=> s_start_low) // RULE_02
      else $error("Start bit not driven low after load");
   a_cts_holds_off: assert property ( // RULE_06
      (tx_state_ff == TX_IDLE) && i_cfg.flow_en && cts_n_ff |=> (tx_state_ff == TX_IDLE))
      else $error("Transmit started while clear-to-send high");
   a_tx_idle_mark: assert property ((tx_state_ff == TX_IDLE) [*2] |-> o_txd) // RULE_02
      else $error("Transmit line not high while idle");
   a_rts_full: assert property ( // RULE_03
      i_cfg.flow_en && rx_valid_ff && !i_rx_ack |=> ##1 o_rts_n)
      else $error("Request-to-send low while holding word full");
   a_rts_free: assert property (!i_cfg.flow_en |=> ##1 !o_rts_n) // RULE_03
      else $error("Request-to-send high with flow control off");
   a_rx_hold: assert property ( // RULE_02
      rx_valid_ff && !i_rx_ack |=> rx_valid_ff && $stable(o_rx_word))
      else $error("Held receive word changed before acknowledge");
   a_rx_overrun: assert property ( // RULE_01
      rx_done && rx_valid_ff && !i_rx_ack |=> o_rx_overrun)
      else $error("Lost character did not raise overrun");
   a_stop_length: assert property ( // RULE_05
      (tx_state_ff == TX_STOP) && tick && (tx_tk_ff < stop_ticks - 6'h01)
      |=> (tx_state_ff == TX_STOP))
      else $error("Stop period ended early");
endmodule // uart_port
`default_nettype wire
